// ===== verilog/cfg_pkg.sv
package cfg_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 4;
    localparam int CONFIG_CLOCK_HALF_NS    = 50;
    localparam int CONFIG_CLOCK_HALF_CYC   = (CONFIG_CLOCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MASTER_WAIT_NS  = 30000;
    localparam int MASTER_WAIT_CYC = (MASTER_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_CYC       = 32;
    localparam int PROM_ACCESS_CYC = 4;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] LENGTH_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS   = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

    localparam int CTRL_DONE_PULLUP_BIT = 0;
    localparam int CTRL_DONE_HOLD_BIT   = 1;
    localparam int CTRL_READBACK_BIT    = 2;
    localparam int STAT_MODE_LSB        = 0;
    localparam int STAT_STATE_LSB       = 4;
    localparam int STAT_BUSY_BIT        = 8;
    localparam int STAT_ERROR_BIT       = 9;
    localparam int IRQ_DONE_BIT         = 0;
    localparam int IRQ_ERROR_BIT        = 1;
    localparam int IRQ_MODE_BIT         = 2;
    localparam int IRQ_RSVD_BIT         = 3;

    localparam logic [2:0]  CTRL_RESET     = 3'h1;
    localparam logic [23:0] LENGTH_RESET   = 24'h000100;
    localparam logic [3:0]  IRQ_MASK_RESET = 4'h0;

    // ----------------------------------------------------------------
    // Mode pin codes
    // ----------------------------------------------------------------
    localparam logic [2:0] CODE_SLAVE      = 3'h7;
    localparam logic [2:0] CODE_MODE_MASTER_SERIAL = 3'h0;
    localparam logic [2:0] CODE_SYNC_PER   = 3'h3;
    localparam logic [2:0] CODE_ASYNC_PER  = 3'h5;
    localparam logic [2:0] CODE_MPAR_HIGH  = 3'h6;
    localparam logic [2:0] CODE_MPAR_LOW   = 3'h4;

    typedef enum logic [2:0] {
        mode_slave,
        mode_master_serial,
        mode_sync_peripheral,
        mode_async_peripheral,
        mode_master_par_high,
        mode_master_par_low,
        mode_reserved
    } cfg_mode_t;

    typedef enum logic [2:0] {
        ST_CLEAR,
        ST_CLEAR_LAST,
        ST_WAIT,
        ST_DELAY,
        ST_CONFIG,
        ST_HOLD,
        ST_USER,
        ST_RESERVED
    } cfg_state_t;

    typedef enum logic [1:0] {
        FETCH_ACCESS,
        FETCH_STROBE
    } fetch_t;

endpackage : cfg_pkg

// ===== verilog/config_mode_pin_control.sv
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps

// Function
// - Decode mode pins into six modes
// - Drive config_clock in master and async peripheral
// - After config, clock pulled up, readback select
// - Completion pin signals end, options set behaviour
// - External low completion delays user start
// - Reconfig request low keeps clearing memory
// - On release, finish clear, clear again, wait
// - Ready output shows when next byte accepted
// - Async status read puts ready on bit 7
// - Address strobe rises before each address change
// - High and low config flags until complete
// - Unused outputs tri-stated, weakly high, during config
// - Error pulls init pin low, open drain
// - After config, special pins return to user
// - Capture mode pins before configuration starts
// - Selected when select pins active, write wins
// - Serial out changes on falling edge, 1.5 periods
module config_mode_pin_control
    import cfg_pkg::*;
#(
    parameter int MASTER_WAIT = MASTER_WAIT_CYC,
    parameter int CLEAR_LEN   = CLEAR_CYC,
    parameter int ADDR_W      = 18
)(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              mode_pin_0,
    input  wire logic              mode_pin_1,
    input  wire logic              mode_pin_2,
    input  wire logic              program_n,
    input  wire logic              init_in,
    output logic                   init_out,
    output logic                   init_oe,
    input  wire logic              done_in,
    output logic                   done_out,
    output logic                   done_oe,
    output logic                   done_pullup,
    input  wire logic              config_clock_in,
    output logic                   config_clock_out,
    output logic                   config_clock_oe,
    output logic                   config_clock_pullup,
    output logic                   readback_clock_sel,
    input  wire logic              serial_din,
    output logic                   serial_dout,
    output logic                   serial_dout_oe,
    input  wire logic [7:0]        parallel_config_data_in,
    output logic      [7:0]        parallel_config_data_out,
    output logic      [7:0]        parallel_config_data_oe,
    input  wire logic              select_low_active,
    input  wire logic              select_high_active,
    input  wire logic              write_strobe_n,
    input  wire logic              read_strobe_n,
    output logic                   ready_busy,
    output logic                   ready_busy_oe,
    output logic      [ADDR_W-1:0] prom_address,
    output logic                   prom_address_oe,
    output logic                   address_strobe,
    output logic                   address_strobe_oe,
    output logic                   high_during_config,
    output logic                   low_during_config,
    output logic                   config_flags_oe,
    output logic                   weak_pullup_en,
    output logic                   user_io_release,
    output logic                   memory_clear
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    localparam int SW = 20;
    logic [SW-1:0] meta_q;
    logic [SW-1:0] sync_q;
    logic [7:0]    data_s;
    logic          rs_s, ws_s, cs1_s, cs0_s, din_s, config_clock_s, done_s, init_s, prog_s;
    logic [2:0]    mpin_s;

    always_ff @(posedge ref_clk)
    begin
        meta_q <= {parallel_config_data_in, read_strobe_n, write_strobe_n,
                   select_high_active, select_low_active, serial_din, config_clock_in,
                   done_in, init_in, program_n, mode_pin_2, mode_pin_1, mode_pin_0};
        sync_q <= meta_q;
    end

    assign {data_s, rs_s, ws_s, cs1_s, cs0_s, din_s, config_clock_s, done_s, init_s, prog_s,
            mpin_s} = sync_q;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    cfg_state_t        st_q, st_d;
    cfg_mode_t         mode_q, mode_d;
    fetch_t            fetch_q, fetch_d;
    logic [2:0]        code_q, code_d, ctrl_q, ctrl_d;
    logic [23:0]       len_q, len_d, bitcnt_q, bitcnt_d;
    logic [3:0]        ist_q, ist_d, imask_q, imask_d, ev;
    logic [15:0]       cnt_q, cnt_d;
    logic [7:0]        div_q, div_d, shift_q, shift_d, hold_q, hold_d;
    logic [3:0]        left_q, left_d;
    logic              hold_full_q, hold_full_d, err_q, err_d;
    logic              stage0_q, stage0_d, stage1_q, stage1_d;
    logic              config_clock_prev_q, ws_prev_q;
    logic [31:0]       prdata_d;
    logic              pready_d, pslverr_d;
    logic              config_clock_out_d, dout_d, strobe_d;
    logic [ADDR_W-1:0] addr_d;

    logic master, par_master, periph, drives_config_clock, tick, rise, fall, bit_in, bit_ok;
    logic selected, ws_fall, wr_ok, status_read;
    logic [31:0] rd_val;

    always_comb
    begin
        master      = mode_q inside {mode_master_serial, mode_master_par_high,
                                     mode_master_par_low};
        par_master  = mode_q inside {mode_master_par_high, mode_master_par_low};
        periph      = mode_q inside {mode_sync_peripheral, mode_async_peripheral};
        drives_config_clock = master || mode_q == mode_async_peripheral;
        wr_ok       = !hold_full_q || left_q == 4'h0;
        tick        = div_q == 8'h00;
        rise        = drives_config_clock ? (tick && !config_clock_out) : (config_clock_s && !config_clock_prev_q);
        fall        = drives_config_clock ? (tick && config_clock_out) : (!config_clock_s && config_clock_prev_q);
        bit_ok      = (mode_q inside {mode_slave, mode_master_serial}) || left_q != 4'h0;
        bit_in      = (mode_q inside {mode_slave, mode_master_serial}) ? din_s : shift_q[0];
        selected    = !cs0_s && cs1_s;
        ws_fall     = selected && !ws_s && ws_prev_q;
        status_read = mode_q == mode_async_peripheral && selected && !rs_s && ws_s;

        st_d = st_q;  mode_d = mode_q;  fetch_d = fetch_q;  code_d = code_q;
        ctrl_d = ctrl_q;  len_d = len_q;  bitcnt_d = bitcnt_q;  imask_d = imask_q;
        cnt_d = cnt_q;  div_d = div_q;  shift_d = shift_q;  hold_d = hold_q;
        left_d = left_q;  hold_full_d = hold_full_q;  err_d = err_q;
        stage0_d = stage0_q;  stage1_d = stage1_q;  ev = 4'h0;
        config_clock_out_d = config_clock_out;  dout_d = serial_dout;
        strobe_d = address_strobe;  addr_d = prom_address;

        // ------------------------------------------------------------
        // Sequencing
        // ------------------------------------------------------------
        case (st_q)
            ST_CLEAR:
            begin
                if (cnt_q == 16'h0000)
                begin
                    cnt_d = 16'(CLEAR_LEN - 1);
                    if (prog_s)
                        st_d = ST_CLEAR_LAST;
                end
                else
                    cnt_d = cnt_q - 16'h0001;
            end
            ST_CLEAR_LAST:
            begin
                if (cnt_q == 16'h0000)
                    st_d = ST_WAIT;
                else
                    cnt_d = cnt_q - 16'h0001;
            end
            ST_WAIT:
            begin
                if (init_s)
                begin
                    code_d = mpin_s;
                    ev[IRQ_MODE_BIT] = 1'b1;
                    case (mpin_s)
                        CODE_SLAVE:      mode_d = mode_slave;
                        CODE_MODE_MASTER_SERIAL: mode_d = mode_master_serial;
                        CODE_SYNC_PER:   mode_d = mode_sync_peripheral;
                        CODE_ASYNC_PER:  mode_d = mode_async_peripheral;
                        CODE_MPAR_HIGH:  mode_d = mode_master_par_high;
                        CODE_MPAR_LOW:   mode_d = mode_master_par_low;
                        default:         mode_d = mode_reserved;
                    endcase
                    cnt_d = 16'(MASTER_WAIT - 1);
                    bitcnt_d = 24'h000000;
                    left_d = 4'h0;
                    hold_full_d = 1'b0;
                    addr_d = '0;
                    fetch_d = FETCH_ACCESS;
                    div_d = 8'(CONFIG_CLOCK_HALF_CYC - 1);
                    if (mode_d == mode_reserved)
                    begin
                        st_d = ST_RESERVED;
                        ev[IRQ_RSVD_BIT] = 1'b1;
                    end
                    else if (mode_d inside {mode_master_serial, mode_master_par_high,
                                            mode_master_par_low})
                        st_d = ST_DELAY;
                    else
                        st_d = ST_CONFIG;
                end
            end
            ST_DELAY:
            begin
                if (cnt_q == 16'h0000)
                begin
                    st_d = ST_CONFIG;
                    cnt_d = 16'(PROM_ACCESS_CYC - 1);
                end
                else
                    cnt_d = cnt_q - 16'h0001;
            end
            ST_CONFIG:
            begin
                if (drives_config_clock)
                begin
                    div_d = tick ? 8'(CONFIG_CLOCK_HALF_CYC - 1) : div_q - 8'h01;
                    if (tick)
                        config_clock_out_d = !config_clock_out;
                end
                if (left_q == 4'h0 && hold_full_q)
                begin
                    shift_d = hold_q;
                    left_d = 4'h8;
                    hold_full_d = 1'b0;
                end
                if (rise)
                begin
                    stage1_d = stage0_q;
                    if (bit_ok)
                    begin
                        stage0_d = bit_in;
                        bitcnt_d = bitcnt_q + 24'h000001;
                        if (left_q != 4'h0)
                        begin
                            shift_d = {1'b0, shift_q[7:1]};
                            left_d = left_q - 4'h1;
                        end
                        if (bitcnt_q == len_q - 24'h000001)
                        begin
                            ev[IRQ_DONE_BIT] = 1'b1;
                            st_d = (ctrl_q[CTRL_DONE_HOLD_BIT] && !done_s) ? ST_HOLD
                                                                           : ST_USER;
                        end
                    end
                end
                if (fall)
                    dout_d = stage1_q;
                if (periph && ws_fall)
                begin
                    if (wr_ok)
                    begin
                        hold_d = data_s;
                        hold_full_d = 1'b1;
                    end
                    else
                    begin
                        err_d = 1'b1;
                        ev[IRQ_ERROR_BIT] = 1'b1;
                    end
                end
                if (par_master)
                begin
                    case (fetch_q)
                        FETCH_ACCESS:
                        begin
                            if (cnt_q != 16'h0000)
                                cnt_d = cnt_q - 16'h0001;
                            else if (wr_ok)
                            begin
                                hold_d = data_s;
                                hold_full_d = 1'b1;
                                strobe_d = 1'b1;
                                fetch_d = FETCH_STROBE;
                            end
                        end
                        FETCH_STROBE:
                        begin
                            addr_d = prom_address + 1'b1;
                            strobe_d = 1'b0;
                            cnt_d = 16'(PROM_ACCESS_CYC - 1);
                            fetch_d = FETCH_ACCESS;
                        end
                        default: fetch_d = FETCH_ACCESS;
                    endcase
                end
            end
            ST_HOLD:
            begin
                if (done_s)
                    st_d = ST_USER;
            end
            ST_USER:     st_d = ST_USER;
            ST_RESERVED: st_d = ST_RESERVED;
            default:     st_d = ST_CLEAR;
        endcase
        if (!prog_s)
        begin
            st_d = ST_CLEAR;
            err_d = 1'b0;
            config_clock_out_d = 1'b0;
            strobe_d = 1'b0;
            if (st_q != ST_CLEAR)
                cnt_d = 16'(CLEAR_LEN - 1);
        end

        // ------------------------------------------------------------
        // Register bus
        // ------------------------------------------------------------
        rd_val = 32'h00000000;
        pslverr_d = 1'b0;
        case (paddr)
            CTRL_OFS:     rd_val = {29'h0, ctrl_q};
            LENGTH_OFS:   rd_val = {8'h00, len_q};
            STATUS_OFS:   rd_val = {22'h0, err_q, hold_full_q, 1'b0, 3'(st_q), 1'b0, code_q};
            IRQ_STAT_OFS: rd_val = {28'h0, ist_q};
            IRQ_MASK_OFS: rd_val = {28'h0, imask_q};
            default:      pslverr_d = psel && !penable;
        endcase
        pready_d = psel && !penable;
        prdata_d = pready_d ? rd_val : prdata;
        ist_d = ist_q | ev;
        if (psel && penable && pready && pwrite && !pslverr)
        begin
            case (paddr)
                CTRL_OFS:     ctrl_d = pwdata[2:0];
                LENGTH_OFS:   len_d = pwdata[23:0];
                IRQ_STAT_OFS: ist_d = (ist_q & ~pwdata[3:0]) | ev;
                IRQ_MASK_OFS: imask_d = pwdata[3:0];
                default:      ctrl_d = ctrl_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers and pin drivers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        config_clock_prev_q <= config_clock_s;
        ws_prev_q   <= ws_s;
        if (!rst_b)
        begin
            st_q <= ST_CLEAR;  mode_q <= mode_reserved;  fetch_q <= FETCH_ACCESS;
            code_q <= 3'h0;  ctrl_q <= CTRL_RESET;  len_q <= LENGTH_RESET;
            bitcnt_q <= 24'h000000;  ist_q <= 4'h0;  imask_q <= IRQ_MASK_RESET;
            cnt_q <= 16'(CLEAR_LEN - 1);  div_q <= 8'h00;  shift_q <= 8'h00;
            hold_q <= 8'h00;  left_q <= 4'h0;  hold_full_q <= 1'b0;  err_q <= 1'b0;
            stage0_q <= 1'b1;  stage1_q <= 1'b1;
            prdata <= 32'h00000000;  pready <= 1'b0;  pslverr <= 1'b0;  irq <= 1'b0;
            init_out <= 1'b0;  init_oe <= 1'b1;  done_out <= 1'b0;  done_oe <= 1'b1;
            done_pullup <= 1'b0;  config_clock_out <= 1'b0;  config_clock_oe <= 1'b0;
            config_clock_pullup <= 1'b0;  readback_clock_sel <= 1'b0;
            serial_dout <= 1'b1;  serial_dout_oe <= 1'b0;
            parallel_config_data_out <= 8'hff;  parallel_config_data_oe <= 8'h00;
            ready_busy <= 1'b0;  ready_busy_oe <= 1'b0;
            prom_address <= '0;  prom_address_oe <= 1'b0;
            address_strobe <= 1'b0;  address_strobe_oe <= 1'b0;
            high_during_config <= 1'b1;  low_during_config <= 1'b0;
            config_flags_oe <= 1'b1;  weak_pullup_en <= 1'b1;
            user_io_release <= 1'b0;  memory_clear <= 1'b1;
        end
        else
        begin
            st_q <= st_d;  mode_q <= mode_d;  fetch_q <= fetch_d;  code_q <= code_d;
            ctrl_q <= ctrl_d;  len_q <= len_d;  bitcnt_q <= bitcnt_d;
            ist_q <= ist_d;  imask_q <= imask_d;  cnt_q <= cnt_d;  div_q <= div_d;
            shift_q <= shift_d;  hold_q <= hold_d;  left_q <= left_d;
            hold_full_q <= hold_full_d;  err_q <= err_d;
            stage0_q <= stage0_d;  stage1_q <= stage1_d;
            prdata <= prdata_d;  pready <= pready_d;  pslverr <= pslverr_d;
            irq <= |(ist_d & imask_d);
            init_out <= 1'b0;
            init_oe <= st_d inside {ST_CLEAR, ST_CLEAR_LAST} || err_d;
            done_out <= st_d == ST_USER && !ctrl_d[CTRL_DONE_PULLUP_BIT];
            done_oe <= !(st_d inside {ST_HOLD, ST_USER}) ||
                       (st_d == ST_USER && !ctrl_d[CTRL_DONE_PULLUP_BIT]);
            done_pullup <= ctrl_d[CTRL_DONE_PULLUP_BIT];
            config_clock_out <= config_clock_out_d;
            config_clock_oe <= st_d == ST_CONFIG && drives_config_clock;
            config_clock_pullup <= st_d == ST_USER;
            readback_clock_sel <= st_d == ST_USER && ctrl_d[CTRL_READBACK_BIT];
            serial_dout <= dout_d;
            serial_dout_oe <= st_d inside {ST_CONFIG, ST_HOLD};
            parallel_config_data_out <= {!hold_full_d, 7'h7f};
            parallel_config_data_oe <= (st_d == ST_CONFIG && status_read) ? 8'hff
                                                                           : 8'h00;
            ready_busy <= !hold_full_d;
            ready_busy_oe <= st_d == ST_CONFIG && periph;
            prom_address <= addr_d;
            prom_address_oe <= st_d == ST_CONFIG && par_master;
            address_strobe <= strobe_d;
            address_strobe_oe <= st_d == ST_CONFIG && par_master;
            high_during_config <= 1'b1;
            low_during_config <= 1'b0;
            config_flags_oe <= st_d != ST_USER;
            weak_pullup_en <= st_d != ST_USER;
            user_io_release <= st_d == ST_USER;
            memory_clear <= st_d inside {ST_CLEAR, ST_CLEAR_LAST};
        end
    end

endmodule : config_mode_pin_control

// ===== tb/cfg_pin_checker_properties.sv
`timescale 1ns/1ps
module cfg_pin_checker (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic program_n,
    input wire logic memory_clear,
    input wire logic init_oe,
    input wire logic init_out,
    input wire logic config_flags_oe,
    input wire logic high_during_config,
    input wire logic low_during_config,
    input wire logic weak_pullup_en,
    input wire logic user_io_release
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    AST_FLAGS: assert property (config_flags_oe |-> high_during_config && !low_during_config)
        else $error("config flags wrong");
    AST_CLEAR: assert property (!program_n [*4] |=> memory_clear && init_oe)
        else $error("clear not held");
    AST_LAST: assert property ($rose(program_n) && memory_clear |=> memory_clear [*3])
        else $error("clear ended early");
    AST_OPEN_DRAIN: assert property (init_oe |-> !init_out)
        else $error("init pin driven high");
    AST_USER: assert property (user_io_release |-> !config_flags_oe && !weak_pullup_en)
        else $error("pins not released");
    AST_PULL: assert property (!user_io_release |-> weak_pullup_en)
        else $error("pull-up missing");
    AST_SETUP: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("ready too long");
endmodule : cfg_pin_checker
bind config_mode_pin_control cfg_pin_checker chk (.*);

// ===== tb/cfg_far_side.sv
`timescale 1ns/1ps
module cfg_far_side (
    input  wire logic init_oe,
    input  wire logic done_oe,
    input  wire logic done_out,
    input  wire logic config_clock_oe,
    input  wire logic user_io_release,
    output logic      init_in,
    output logic      done_in,
    output logic      config_clock_in
);
    // Pulled-up open-drain pins
    assign init_in = !init_oe;
    assign done_in = done_oe ? done_out : 1'b1;
    // Clock supplied only while the device does not drive it
    initial
    begin
        config_clock_in = 1'b1;
        forever
            #40 config_clock_in = (config_clock_oe || user_io_release) ? 1'b1 : !config_clock_in;
    end
endmodule : cfg_far_side

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench
    import cfg_pkg::*;
;
    logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
    logic [7:0] paddr = 8'h00, parallel_config_data_in = 8'h00;
    logic [7:0] parallel_config_data_out, parallel_config_data_oe;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic mode_pin_0 = 1, mode_pin_1 = 1, mode_pin_2 = 1, program_n = 1, serial_din = 0;
    logic init_in, init_out, init_oe, done_in, done_out, done_oe, done_pullup, serial_dout;
    logic config_clock_in, config_clock_out, config_clock_oe, config_clock_pullup;
    logic readback_clock_sel, serial_dout_oe, ready_busy, ready_busy_oe, address_strobe;
    logic select_low_active = 1, select_high_active = 0, write_strobe_n = 1, read_strobe_n = 1;
    logic prom_address_oe, address_strobe_oe, high_during_config, low_during_config;
    logic config_flags_oe, weak_pullup_en, user_io_release, memory_clear;
    logic [17:0] prom_address;
    int fails = 0, total_checks = 0, cyc = 0;
    config_mode_pin_control #(.MASTER_WAIT(20), .CLEAR_LEN(4)) uut (.*);
    cfg_far_side far_side (.*);
    always #2 ref_clk = !ref_clk;
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        fails += (got !== exp);
        if (got !== exp) $display("[FAIL] %s expected %h seen %h", what, exp, got);
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(negedge ref_clk);
    endtask : apb
    task automatic wait_state(input logic [2:0] st);
        int n = 0;
        do apb(1'b0, STATUS_OFS, 32'h0);
        while (rd[6:4] !== st && n++ < 300);
    endtask : wait_state
    task automatic t_regs;
        check("reset pins", 4'hb, {high_during_config, low_during_config, memory_clear, init_oe});
        apb(1'b0, CTRL_OFS, 32'h0);
        check("ctrl", 32'h1, rd);
        apb(1'b0, LENGTH_OFS, 32'h0);
        check("length", 32'h100, rd);
        apb(1'b1, 8'h20, 32'hffff_ffff);
        check("slverr", 32'h1, err);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped", 32'h0, rd);
        wait_state(3'h4);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        check("captured", 32'h1, rd[IRQ_MODE_BIT]);
        check("masked irq", 32'h0, irq);
        $display("test registers done");
    endtask : t_regs
    task automatic t_modes;
        logic [2:0] codes [8] = '{3'h7, 3'h0, 3'h3, 3'h5, 3'h6, 3'h4, 3'h2, 3'h1};
        apb(1'b1, IRQ_MASK_OFS, 32'hc);
        foreach (codes[i])
        begin
            @(posedge ref_clk);
            {mode_pin_2, mode_pin_1, mode_pin_0, program_n} <= {codes[i], 1'b0};
            repeat (8) @(posedge ref_clk);
            program_n <= 1'b1;
            wait_state(i < 6 ? 3'h4 : 3'h7);
            check("mode", codes[i], rd[2:0]);
            check("state", i < 6 ? 4 : 7, rd[6:4]);
            check("clock drive", codes[i] inside {3'h0, 3'h5, 3'h6, 3'h4}, config_clock_oe);
            check("prom drive", {2{codes[i] inside {3'h6, 3'h4}}}, {prom_address_oe, address_strobe_oe});
            check("ready oe", codes[i] inside {3'h3, 3'h5}, ready_busy_oe);
            check("irq", 32'h1, irq);
            apb(1'b1, IRQ_STAT_OFS, 32'hf);
            check("irq cleared", 32'h0, irq);
            @(posedge ref_clk);
            {select_low_active, select_high_active, read_strobe_n} <= 3'b010;
            repeat (5) @(negedge ref_clk);
            check("status oe", {8{codes[i] == CODE_ASYNC_PER}}, parallel_config_data_oe);
            if (codes[i] == CODE_ASYNC_PER) check("status", 8'hff, parallel_config_data_out);
            @(posedge ref_clk);
            {select_low_active, select_high_active, read_strobe_n} <= 3'b101;
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_done;
        apb(1'b1, LENGTH_OFS, 32'h4);
        apb(1'b1, CTRL_OFS, 32'h5);
        @(posedge ref_clk);
        {mode_pin_2, mode_pin_1, mode_pin_0, program_n, serial_din} <= 5'b11101;
        repeat (8) @(posedge ref_clk);
        program_n <= 1'b1;
        wait_state(3'h6);
        check("done", 3'h1, {done_out, done_oe, done_pullup});
        check("user", 3'h5, {user_io_release, config_flags_oe, config_clock_pullup});
        check("readback", 32'h1, readback_clock_sel);
        check("serial out", 32'h1, serial_dout);
        $display("test completion done");
    endtask : t_done
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    always @(posedge ref_clk)
        if (++cyc > 60000)
        begin
            fails++;
            end_of_test();
        end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        t_regs();
        t_modes();
        t_done();
        end_of_test();
    end
endmodule : testbench
